// ### logic/ici_pkg.sv
// Shared constants and types of the byte-coded I/O command interpreter.
// Assumes one clock domain and byte streams on both the command side and
// the result side.
package ici_pkg;

	// ==========================================================
	// Geometry
	localparam int NUM_PORTS = 5;
	localparam int BYTE_W = 8;
	localparam int ADC_W = 10;
	localparam int CHAN_W = 4;

	// ==========================================================
	// Command codes
	localparam logic [7:0] OPC_PREFIX = 8'h0B;
	localparam logic [7:0] OPC_EXIT = 8'h00;
	localparam logic [1:0] FAMILY_HI = 2'h3;
	localparam logic [3:0] OPC_SPI_PARAMS = 4'h1;
	localparam logic [3:0] OPC_DIR_WRXOR = 4'h2;
	localparam logic [3:0] OPC_ADC_ALL = 4'h3;
	localparam logic [3:0] OPC_PORT_RW = 4'h7;
	localparam logic [3:0] OPC_PORT_XOR = 4'h9;

	// Sub-commands carried in the upper nibble after the prefix
	localparam logic [3:0] SUB_SPI_CLOCK = 4'h0;
	localparam logic [3:0] SUB_USART_BAUD = 4'h1;

	// SPI clock choices in the low two bits
	localparam logic [1:0] SPI_RATE_12M = 2'h0;
	localparam logic [1:0] SPI_RATE_3M = 2'h1;
	localparam logic [1:0] SPI_RATE_750K = 2'h2;
	localparam logic [1:0] SPI_RATE_TIMER = 2'h3;

	// Rate timer prescaler codes
	localparam logic [1:0] PRESCALE_1 = 2'h0;
	localparam logic [1:0] PRESCALE_4 = 2'h1;
	localparam logic [1:0] PRESCALE_16 = 2'h2;
	localparam logic [1:0] PRESCALE_RSVD = 2'h3;

	// ==========================================================
	// Field positions
	localparam int SPI_IDLE_BIT = 4;
	localparam int SPI_SAMPLE_BIT = 5;
	localparam int PRESCALE_LSB = 2;
	localparam int CMP1_BIT = 6;
	localparam int CMP2_BIT = 7;
	localparam int SEL_W = 5;

	// ==========================================================
	// Reset values
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam logic [7:0] PERIOD_RESET = 8'hFF;
	localparam logic [15:0] DIVIDER_RESET = 16'h0000;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [1:0] rate_sel;
		logic [1:0] timer_prescale_field;
		logic [7:0] spi_rate_timer;
		logic clock_idles_high_param;
		logic sample_late_param;
	} ici_spi_cfg_t;

	typedef struct packed {
		logic high_speed;
		logic [15:0] divider;
	} ici_usart_cfg_t;

	typedef struct packed {
		logic en;
		logic use_xor;
		logic dir;
		logic [2:0] idx;
		logic [7:0] data;
	} ici_bank_op_t;

	typedef enum logic [3:0] {
		ST_OPCODE = 4'h0,
		ST_SUB = 4'h1,
		ST_SPI_PERIOD = 4'h2,
		ST_BAUD_LO = 4'h3,
		ST_BAUD_HI = 4'h4,
		ST_PSEL_RD = 4'h5,
		ST_PSEL_WR = 4'h6,
		ST_PORT_RD = 4'h7,
		ST_PORT_WR = 4'h8,
		ST_TSEL = 4'h9,
		ST_PIN_DIRECTION_REGISTER = 4'hA,
		ST_ADC_START = 4'hB,
		ST_ADC_WAIT = 4'hC,
		ST_ADC_LO = 4'hD,
		ST_ADC_HI = 4'hE
	} ici_state_t;

endpackage : ici_pkg

// ### logic/ici_port_bank.sv
// Port output latches and pin direction registers of ports A to E.
// Assumes the interpreter issues at most one operation per cycle.
`timescale 1ns/1ps

module ici_port_bank #(
	parameter int PORTS = ici_pkg::NUM_PORTS
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire ici_pkg::ici_bank_op_t op_i,
	output logic [PORTS-1:0][7:0] latch_o,
	output logic [PORTS-1:0][7:0] dir_o
);

	// ==========================================================
	// One latch and one direction register per port
	genvar g;
	generate
		for (g = 0; g < PORTS; g++) begin : g_port
			// Latch: plain write or exclusive-or with the operand
			always_ff @(posedge core_clk_i or posedge rst_i) begin
				if (rst_i) begin
					latch_o[g] <= ici_pkg::LATCH_RESET;
				end else if (op_i.en && !op_i.dir && op_i.idx == 3'(g)) begin
					latch_o[g] <= op_i.use_xor ? (latch_o[g] ^ op_i.data)
						: op_i.data;
				end
			end

			// Direction register: same operations
			always_ff @(posedge core_clk_i or posedge rst_i) begin
				if (rst_i) begin
					dir_o[g] <= ici_pkg::DIR_RESET;
				end else if (op_i.en && op_i.dir && op_i.idx == 3'(g)) begin
					dir_o[g] <= op_i.use_xor ? (dir_o[g] ^ op_i.data)
						: op_i.data;
				end
			end
		end
	endgenerate

endmodule : ici_port_bank

// ### logic/ici_interp.sv
// Byte-coded command interpreter: decodes a command byte stream, updates
// SPI, USART, port and direction settings and returns result bytes.
// Assumes command and result streams, the converter and its configured
// top channel are on core_clk_i; port pins and comparators are not.
//
// How it works
// - Prefix byte announces clock and baud sub-commands
// - Upper nibble after prefix selects sub-command
// - Low two bits pick SPI clock source
// - With timer clock choice, bits 3:2 set prescaler; 11 reserved
// - Timer clock choice takes one period byte
// - Baud bit 0 selects divide-16 or divide-4
// - Two following bytes load sixteen-bit baud divider
// - Bit 4 idle level, bit 5 sample instant
// - Two select bytes: read and write per port
// - Write bytes consumed in order A to E
// - One result byte per read port, A to E
// - Ports A, C, E carry comparators in 7:6
// - XOR variant exclusive-ors latches with operands
// - Direction writes first, then XORs, A to E
// - Read-all converts channel zero up to top
// - Result low byte, then bits 9:8 in low bits
// - Second result byte top bits hold comparators
`timescale 1ns/1ps

module ici_interp (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_data_i,
	output logic cmd_ready_o,
	output logic res_valid_o,
	output logic [7:0] res_data_o,
	input wire logic res_ready_i,
	input wire logic [ici_pkg::NUM_PORTS-1:0][7:0] port_pins_i,
	output logic [ici_pkg::NUM_PORTS-1:0][7:0] port_latch_o,
	output logic [ici_pkg::NUM_PORTS-1:0][7:0] pin_direction_register_o,
	input wire logic [1:0] cmp_pins_i,
	output ici_pkg::ici_spi_cfg_t spi_cfg_o,
	output ici_pkg::ici_usart_cfg_t usart_cfg_o,
	input wire logic [ici_pkg::CHAN_W-1:0] adc_top_chan_i,
	output logic adc_start_o,
	output logic [ici_pkg::CHAN_W-1:0] adc_chan_o,
	input wire logic adc_done_i,
	input wire logic [ici_pkg::ADC_W-1:0] adc_result_i
);

	// ==========================================================
	// Declarations
	ici_pkg::ici_state_t state;
	ici_pkg::ici_state_t next_state;
	ici_pkg::ici_bank_op_t bank_op;
	logic [ici_pkg::NUM_PORTS-1:0][7:0] pin_meta;
	logic [ici_pkg::NUM_PORTS-1:0][7:0] pin_sync;
	logic [1:0] cmp_meta;
	logic [1:0] cmp_sync;
	logic [ici_pkg::SEL_W-1:0] rd_sel;
	logic [ici_pkg::SEL_W-1:0] port_write_select;
	logic [ici_pkg::SEL_W-1:0] dir_wr_sel;
	logic [ici_pkg::SEL_W-1:0] direction_xor_select;
	logic port_xor_mode;
	logic [2:0] idx;
	logic [3:0] tidx;
	logic [ici_pkg::ADC_W-1:0] adc_res;
	logic stall;
	logic take;
	logic emit;
	logic [7:0] emit_data;
	logic pin_direction_register_need;
	logic pin_direction_register_is_xor;
	logic [2:0] pin_direction_register_port;
	logic opc_family;

	// ==========================================================
	// Helper functions

	// Port value for the result stream, comparators in the top bits of ports A, C, E
	function automatic logic [7:0] port_read_byte(
		input logic [2:0] p,
		input logic [7:0] pins,
		input logic [1:0] cmp
	);
		logic [7:0] b;
		b = pins;
		if (p == 3'h0 || p == 3'h2 || p == 3'h4) begin
			b[ici_pkg::CMP1_BIT] = cmp[0];
			b[ici_pkg::CMP2_BIT] = cmp[1];
		end
		return b;
	endfunction : port_read_byte

	// Step index over the ten direction slots: writes, then XORs
	function automatic logic [2:0] slot_port(input logic [3:0] t);
		logic [3:0] r;
		r = (t >= 4'(ici_pkg::NUM_PORTS)) ? t - 4'(ici_pkg::NUM_PORTS) : t;
		return r[2:0];
	endfunction : slot_port

	// ==========================================================
	// Pin and comparator synchronisers
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta <= '0;
			pin_sync <= '0;
			cmp_meta <= 2'h0;
			cmp_sync <= 2'h0;
		end else begin
			pin_meta <= port_pins_i;
			pin_sync <= pin_meta;
			cmp_meta <= cmp_pins_i;
			cmp_sync <= cmp_meta;
		end
	end

	// ==========================================================
	// Handshake terms
	assign stall = res_valid_o && !res_ready_i;
	assign opc_family = (cmd_data_i[7:6] == ici_pkg::FAMILY_HI);
	assign pin_direction_register_port = slot_port(tidx);
	assign pin_direction_register_is_xor = (tidx >= 4'(ici_pkg::NUM_PORTS));
	assign pin_direction_register_need = pin_direction_register_is_xor ? direction_xor_select[pin_direction_register_port]
		: dir_wr_sel[pin_direction_register_port];

	// Command bytes are accepted only where an opcode or a parameter is expected
	always_comb begin
		case (state)
			ici_pkg::ST_OPCODE, ici_pkg::ST_SUB, ici_pkg::ST_SPI_PERIOD,
			ici_pkg::ST_BAUD_LO, ici_pkg::ST_BAUD_HI, ici_pkg::ST_PSEL_RD,
			ici_pkg::ST_PSEL_WR, ici_pkg::ST_TSEL: begin
				cmd_ready_o = !stall;
			end
			ici_pkg::ST_PORT_WR: begin
				cmd_ready_o = !stall && port_write_select[idx];
			end
			ici_pkg::ST_PIN_DIRECTION_REGISTER: begin
				cmd_ready_o = !stall && pin_direction_register_need;
			end
			default: begin
				cmd_ready_o = 1'b0;
			end
		endcase
	end
	assign take = cmd_valid_i && cmd_ready_o;

	// ==========================================================
	// Result byte selection
	always_comb begin
		emit = 1'b0;
		emit_data = 8'h00;
		case (state)
			ici_pkg::ST_PORT_RD: begin
				emit = !stall && rd_sel[idx];
				emit_data = port_read_byte(idx, pin_sync[idx], cmp_sync);
			end
			ici_pkg::ST_ADC_LO: begin
				emit = !stall;
				emit_data = adc_res[7:0];
			end
			ici_pkg::ST_ADC_HI: begin
				emit = !stall;
				emit_data = {cmp_sync[1], cmp_sync[0], 4'h0,
					adc_res[9:8]};
			end
			default: begin
				emit = 1'b0;
			end
		endcase
	end

	// Result register, held until the consumer takes it
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			res_valid_o <= 1'b0;
			res_data_o <= 8'h00;
		end else if (emit) begin
			res_valid_o <= 1'b1;
			res_data_o <= emit_data;
		end else if (res_ready_i) begin
			res_valid_o <= 1'b0;
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_state = state;
		case (state)
			ici_pkg::ST_OPCODE: begin
				if (take) begin
					if (cmd_data_i == ici_pkg::OPC_PREFIX) begin
						next_state = ici_pkg::ST_SUB;
					end else if (opc_family &&
						cmd_data_i[3:0] == ici_pkg::OPC_DIR_WRXOR) begin
						next_state = ici_pkg::ST_TSEL;
					end else if (opc_family &&
						cmd_data_i[3:0] == ici_pkg::OPC_ADC_ALL) begin
						next_state = ici_pkg::ST_ADC_START;
					end else if (opc_family &&
						(cmd_data_i[3:0] == ici_pkg::OPC_PORT_RW ||
						cmd_data_i[3:0] == ici_pkg::OPC_PORT_XOR)) begin
						next_state = ici_pkg::ST_PSEL_RD;
					end
				end
			end
			ici_pkg::ST_SUB: begin
				if (take) begin
					if (cmd_data_i[7:4] == ici_pkg::SUB_SPI_CLOCK &&
						cmd_data_i[1:0] == ici_pkg::SPI_RATE_TIMER) begin
						next_state = ici_pkg::ST_SPI_PERIOD;
					end else if (cmd_data_i[7:4] ==
						ici_pkg::SUB_USART_BAUD) begin
						next_state = ici_pkg::ST_BAUD_LO;
					end else begin
						next_state = ici_pkg::ST_OPCODE;
					end
				end
			end
			ici_pkg::ST_SPI_PERIOD: begin
				if (take) begin
					next_state = ici_pkg::ST_OPCODE;
				end
			end
			ici_pkg::ST_BAUD_LO: begin
				if (take) begin
					next_state = ici_pkg::ST_BAUD_HI;
				end
			end
			ici_pkg::ST_BAUD_HI: begin
				if (take) begin
					next_state = ici_pkg::ST_OPCODE;
				end
			end
			ici_pkg::ST_PSEL_RD: begin
				if (take) begin
					next_state = ici_pkg::ST_PSEL_WR;
				end
			end
			ici_pkg::ST_PSEL_WR: begin
				if (take) begin
					next_state = ici_pkg::ST_PORT_RD;
				end
			end
			ici_pkg::ST_PORT_RD: begin
				if (!stall) begin
					next_state = ici_pkg::ST_PORT_WR;
				end
			end
			ici_pkg::ST_PORT_WR: begin
				if (!stall && (take || !port_write_select[idx])) begin
					next_state = (idx == 3'(ici_pkg::NUM_PORTS - 1))
						? ici_pkg::ST_OPCODE : ici_pkg::ST_PORT_RD;
				end
			end
			ici_pkg::ST_TSEL: begin
				if (take) begin
					next_state = ici_pkg::ST_PIN_DIRECTION_REGISTER;
				end
			end
			ici_pkg::ST_PIN_DIRECTION_REGISTER: begin
				if (!stall && (take || !pin_direction_register_need) &&
					tidx == 4'(2 * ici_pkg::NUM_PORTS - 1)) begin
					next_state = ici_pkg::ST_OPCODE;
				end
			end
			ici_pkg::ST_ADC_START: begin
				next_state = ici_pkg::ST_ADC_WAIT;
			end
			ici_pkg::ST_ADC_WAIT: begin
				if (adc_done_i) begin
					next_state = ici_pkg::ST_ADC_LO;
				end
			end
			ici_pkg::ST_ADC_LO: begin
				if (!stall) begin
					next_state = ici_pkg::ST_ADC_HI;
				end
			end
			ici_pkg::ST_ADC_HI: begin
				if (!stall) begin
					next_state = (adc_chan_o >= adc_top_chan_i)
						? ici_pkg::ST_OPCODE : ici_pkg::ST_ADC_START;
				end
			end
			default: begin
				next_state = ici_pkg::ST_OPCODE;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ici_pkg::ST_OPCODE;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// SPI configuration
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			spi_cfg_o.rate_sel <= ici_pkg::SPI_RATE_12M;
			spi_cfg_o.timer_prescale_field <= ici_pkg::PRESCALE_1;
			spi_cfg_o.spi_rate_timer <= ici_pkg::PERIOD_RESET;
			spi_cfg_o.clock_idles_high_param <= 1'b0;
			spi_cfg_o.sample_late_param <= 1'b0;
		end else if (take) begin
			if (state == ici_pkg::ST_SUB &&
				cmd_data_i[7:4] == ici_pkg::SUB_SPI_CLOCK) begin
				spi_cfg_o.rate_sel <= cmd_data_i[1:0];
				if (cmd_data_i[1:0] == ici_pkg::SPI_RATE_TIMER &&
					cmd_data_i[3:2] != ici_pkg::PRESCALE_RSVD) begin
					spi_cfg_o.timer_prescale_field <=
						cmd_data_i[ici_pkg::PRESCALE_LSB +: 2];
				end
			end else if (state == ici_pkg::ST_SPI_PERIOD) begin
				spi_cfg_o.spi_rate_timer <= cmd_data_i;
			end else if (state == ici_pkg::ST_OPCODE && opc_family &&
				cmd_data_i[3:0] == ici_pkg::OPC_SPI_PARAMS) begin
				spi_cfg_o.clock_idles_high_param <=
					cmd_data_i[ici_pkg::SPI_IDLE_BIT];
				spi_cfg_o.sample_late_param <=
					cmd_data_i[ici_pkg::SPI_SAMPLE_BIT];
			end
		end
	end

	// ==========================================================
	// USART baud configuration
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			usart_cfg_o <= '{high_speed: 1'b0,
				divider: ici_pkg::DIVIDER_RESET};
		end else if (take) begin
			if (state == ici_pkg::ST_SUB &&
				cmd_data_i[7:4] == ici_pkg::SUB_USART_BAUD) begin
				usart_cfg_o.high_speed <= cmd_data_i[0];
			end else if (state == ici_pkg::ST_BAUD_LO) begin
				usart_cfg_o.divider[7:0] <= cmd_data_i;
			end else if (state == ici_pkg::ST_BAUD_HI) begin
				usart_cfg_o.divider[15:8] <= cmd_data_i;
			end
		end
	end

	// ==========================================================
	// Port and direction select bytes
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_sel <= '0;
			port_write_select <= '0;
			port_xor_mode <= 1'b0;
			dir_wr_sel <= '0;
			direction_xor_select <= '0;
		end else if (take) begin
			case (state)
				ici_pkg::ST_OPCODE: begin
					port_xor_mode <= (cmd_data_i[3:0] ==
						ici_pkg::OPC_PORT_XOR);
					direction_xor_select[4:3] <= cmd_data_i[5:4];
				end
				ici_pkg::ST_PSEL_RD: begin
					rd_sel <= cmd_data_i[ici_pkg::SEL_W-1:0];
				end
				ici_pkg::ST_PSEL_WR: begin
					port_write_select <= cmd_data_i[ici_pkg::SEL_W-1:0];
				end
				ici_pkg::ST_TSEL: begin
					direction_xor_select[2:0] <= cmd_data_i[7:5];
					dir_wr_sel <= cmd_data_i[ici_pkg::SEL_W-1:0];
				end
				default: begin
					rd_sel <= rd_sel;
				end
			endcase
		end
	end

	// ==========================================================
	// Port and direction step counters
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			idx <= 3'h0;
			tidx <= 4'h0;
		end else if (state == ici_pkg::ST_PSEL_WR) begin
			idx <= 3'h0;
		end else if (state == ici_pkg::ST_TSEL) begin
			tidx <= 4'h0;
		end else if (state == ici_pkg::ST_PORT_WR && !stall &&
			(take || !port_write_select[idx])) begin
			idx <= idx + 3'h1;
		end else if (state == ici_pkg::ST_PIN_DIRECTION_REGISTER && !stall &&
			(take || !pin_direction_register_need)) begin
			tidx <= tidx + 4'h1;
		end
	end

	// Operation handed to the latch bank
	always_comb begin
		bank_op = '0;
		if (take && state == ici_pkg::ST_PORT_WR) begin
			bank_op.en = 1'b1;
			bank_op.use_xor = port_xor_mode;
			bank_op.idx = idx;
			bank_op.data = cmd_data_i;
		end else if (take && state == ici_pkg::ST_PIN_DIRECTION_REGISTER) begin
			bank_op.en = 1'b1;
			bank_op.dir = 1'b1;
			bank_op.use_xor = pin_direction_register_is_xor;
			bank_op.idx = pin_direction_register_port;
			bank_op.data = cmd_data_i;
		end
	end

	// ==========================================================
	// Converter sequencing
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			adc_start_o <= 1'b0;
			adc_chan_o <= '0;
			adc_res <= '0;
		end else begin
			adc_start_o <= (next_state == ici_pkg::ST_ADC_START);
			if (state == ici_pkg::ST_OPCODE) begin
				adc_chan_o <= '0;
			end else if (state == ici_pkg::ST_ADC_HI && !stall) begin
				adc_chan_o <= adc_chan_o + 4'h1;
			end
			if (state == ici_pkg::ST_ADC_WAIT && adc_done_i) begin
				adc_res <= adc_result_i;
			end
		end
	end

	// ==========================================================
	// Latch and direction storage
	ici_port_bank #(
		.PORTS(ici_pkg::NUM_PORTS)
	) u_bank (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.op_i(bank_op),
		.latch_o(port_latch_o),
		.dir_o(pin_direction_register_o)
	);

endmodule : ici_interp

// ### test/ici_host_model.sv
// Host and converter model facing the command interpreter.
// Assumes one clock; the bench queues command bytes in txq.
`timescale 1ns/1ps

module ici_host_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	output logic cmd_valid_o,
	output logic [7:0] cmd_data_o,
	input wire logic cmd_ready_i,
	input wire logic res_valid_i,
	input wire logic [7:0] res_data_i,
	output logic res_ready_o,
	input wire logic adc_start_i,
	input wire logic [3:0] adc_chan_i,
	output logic adc_done_o,
	output logic [9:0] adc_result_o
);
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	logic [3:0] cur;
	int wait_n;

	// ==========================================================
	// Command bytes held until taken; idle line toggles
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_valid_o <= 1'b0;
			cmd_data_o <= 8'h00;
		end else begin
			if (cmd_valid_o && cmd_ready_i)
				void'(txq.pop_front());
			cmd_valid_o <= txq.size() != 0;
			cmd_data_o <= txq.size() != 0 ? txq[0] : ~cmd_data_o;
		end
	end

	// ==========================================================
	// Result bytes collected; slow mode stalls every other cycle
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			res_ready_o <= 1'b0;
		end else begin
			if (res_valid_i && res_ready_o)
				rxq.push_back(res_data_i);
			res_ready_o <= slow_i ? ~res_ready_o : 1'b1;
		end
	end

	// ==========================================================
	// Converter: right-aligned result after a short or long wait
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_n <= 0;
			adc_done_o <= 1'b0;
			adc_result_o <= 10'h000;
		end else if (adc_start_i) begin
			wait_n <= slow_i ? 7 : 1;
			cur <= adc_chan_i;
			adc_done_o <= 1'b0;
		end else if (wait_n == 1) begin
			wait_n <= 0;
			adc_done_o <= 1'b1;
			adc_result_o <= {cur[1:0], cur, 4'h9};
		end else begin
			wait_n <= wait_n > 0 ? wait_n - 1 : 0;
			adc_done_o <= 1'b0;
			adc_result_o <= ~adc_result_o; // Not valid now
		end
	end
endmodule : ici_host_model

// ### test/ici_interp_properties.sv
// Concurrent checks on the command interpreter's ports.
// Assumes a single clock domain and reset rst_i.
`timescale 1ns/1ps

module ici_interp_properties (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic res_valid_o,
	input wire logic [7:0] res_data_o,
	input wire logic res_ready_i,
	input wire logic [ici_pkg::NUM_PORTS-1:0][7:0] port_latch_o,
	input wire logic [ici_pkg::NUM_PORTS-1:0][7:0] pin_direction_register_o,
	input wire ici_pkg::ici_spi_cfg_t spi_cfg_o,
	input wire ici_pkg::ici_usart_cfg_t usart_cfg_o,
	input wire logic [ici_pkg::CHAN_W-1:0] adc_top_chan_i,
	input wire logic adc_start_o,
	input wire logic [ici_pkg::CHAN_W-1:0] adc_chan_o,
	input wire logic adc_done_i
);
	// ==========================================================
	// Byte taken from the command stream
	logic acc;
	assign acc = cmd_valid_i && cmd_ready_o;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	// ==========================================================
	// Converter sequence
	a_start_pulse: assert property (
		adc_start_o |=> !adc_start_o)
		else $error("converter start longer than one cycle");
	a_chan_hold: assert property (
		adc_start_o |=> (!adc_start_o && $stable(adc_chan_o)) until adc_done_i)
		else $error("channel moved during conversion");
	a_chan_bound: assert property (
		adc_start_o |-> adc_chan_o <= adc_top_chan_i)
		else $error("channel beyond top channel");

	// ==========================================================
	// Result stream
	a_res_hold: assert property (
		res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o))
		else $error("result byte dropped or changed");
	a_stall_cmd: assert property (
		res_valid_o && !res_ready_i |-> !cmd_ready_o)
		else $error("command taken while result stalled");

	// ==========================================================
	// Settings change only after a taken byte
	a_spi_cause: assert property (
		!$stable(spi_cfg_o) |-> $past(acc))
		else $error("clock setting changed without a byte");
	a_baud_cause: assert property (
		!$stable(usart_cfg_o) |-> $past(acc))
		else $error("baud setting changed without a byte");
	a_latch_cause: assert property (
		!$stable(port_latch_o) |-> $past(acc) || $past(acc, 2))
		else $error("latch changed without a byte");
	a_dir_cause: assert property (
		!$stable(pin_direction_register_o) |-> $past(acc) || $past(acc, 2))
		else $error("direction changed without a byte");

	c_start: cover property (adc_start_o);
	c_stall: cover property (res_valid_o && !res_ready_i);
	c_b2b: cover property (acc ##1 acc);
endmodule : ici_interp_properties

bind ici_interp ici_interp_properties u_props (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
	.cmd_ready_o(cmd_ready_o), .res_valid_o(res_valid_o),
	.res_data_o(res_data_o), .res_ready_i(res_ready_i),
	.port_latch_o(port_latch_o),
	.pin_direction_register_o(pin_direction_register_o),
	.spi_cfg_o(spi_cfg_o), .usart_cfg_o(usart_cfg_o),
	.adc_top_chan_i(adc_top_chan_i), .adc_start_o(adc_start_o),
	.adc_chan_o(adc_chan_o), .adc_done_i(adc_done_i));

// ### test/ici_interp_tb_top.sv
// Self-checking bench of the command interpreter.
// Assumes the host model answers commands and conversions.
`timescale 1ns/1ps

module ici_interp_tb_top;
	logic core_clk_i, rst_i, slow, cmd_valid, cmd_ready;
	logic res_valid, res_ready, adc_start, adc_done;
	logic [7:0] cmd_data, res_data;
	logic [4:0][7:0] pins, latch, dir;
	logic [1:0] cmp;
	logic [3:0] top, chan;
	logic [9:0] adc_res;
	ici_pkg::ici_spi_cfg_t spi;
	ici_pkg::ici_usart_cfg_t usart;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;

	ici_interp u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.cmd_valid_i(cmd_valid), .cmd_data_i(cmd_data),
		.cmd_ready_o(cmd_ready), .res_valid_o(res_valid),
		.res_data_o(res_data), .res_ready_i(res_ready),
		.port_pins_i(pins), .port_latch_o(latch),
		.pin_direction_register_o(dir), .cmp_pins_i(cmp),
		.spi_cfg_o(spi), .usart_cfg_o(usart), .adc_top_chan_i(top),
		.adc_start_o(adc_start), .adc_chan_o(chan),
		.adc_done_i(adc_done), .adc_result_i(adc_res));

	ici_host_model u_host (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.slow_i(slow), .cmd_valid_o(cmd_valid), .cmd_data_o(cmd_data),
		.cmd_ready_i(cmd_ready), .res_valid_i(res_valid),
		.res_data_i(res_data), .res_ready_o(res_ready),
		.adc_start_i(adc_start), .adc_chan_i(chan),
		.adc_done_o(adc_done), .adc_result_o(adc_res));

	// ==========================================================
	// Clock and hang guard
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			summarize();
		end
	end

	// ==========================================================
	// Helpers
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) u_host.txq.push_back(b[i]);
		u_host.txq.push_back(8'h00); // Exit closes each program
		for (int i = 0; i < 400; i++) begin
			@(posedge core_clk_i);
			#1;
			if (u_host.txq.size() == 0 && !cmd_valid) break;
		end
		@(posedge core_clk_i);
		#1;
	endtask : send

	task automatic chk_res(input logic [7:0] exp);
		logic [7:0] got;
		got = 'x;
		for (int i = 0; i < 60 && u_host.rxq.size() == 0; i++)
			@(posedge core_clk_i);
		if (u_host.rxq.size() != 0) got = u_host.rxq.pop_front();
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t result %h exp %h", $time, got, exp);
		end
	endtask : chk_res

	task automatic chk_cfg(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t setting %h exp %h", $time, got, exp);
		end
	endtask : chk_cfg

	function automatic logic [7:0] exp_pin(input int p);
		if (p % 2 == 0) return {cmp, pins[p][5:0]};
		return pins[p];
	endfunction : exp_pin

	// ==========================================================
	// Scenarios
	task automatic t_spi_clock;
		for (int r = 0; r < 3; r++) begin
			send('{8'h0B, 8'(r)});
			chk_cfg(16'(spi.rate_sel), 16'(r));
		end
		send('{8'h0B, 8'h01, 8'h0B, 8'h00});
		chk_cfg(16'(spi.rate_sel), 16'h0000);
		send('{8'h0B, 8'h07, 8'h0B, 8'hF1});
		chk_cfg(16'(spi.rate_sel), 16'h0003);
		chk_cfg(16'(spi.timer_prescale_field), 16'h0001);
		chk_cfg(16'(spi.spi_rate_timer), 16'h000B);
		chk_cfg(16'(spi.sample_late_param), 16'h0001);
		send('{8'h0B, 8'h0B, 8'h20});
		chk_cfg(16'(spi.timer_prescale_field), 16'h0002);
		send('{8'h0B, 8'h03, 8'h40});
		chk_cfg(16'(spi.timer_prescale_field), 16'h0000);
		chk_cfg(16'(spi.spi_rate_timer), 16'h0040);
		send('{8'h0B, 8'h0F, 8'h33, 8'h0B, 8'h25});
		chk_cfg(16'(spi.timer_prescale_field), 16'h0000);
		chk_cfg(16'(spi.spi_rate_timer), 16'h0033);
	endtask : t_spi_clock

	task automatic t_baud;
		send('{8'h0B, 8'h11, 8'h34, 8'h12});
		chk_cfg(16'(usart.high_speed), 16'h0001);
		chk_cfg(usart.divider, 16'h1234);
		send('{8'h0B, 8'h10, 8'hCD, 8'hAB});
		chk_cfg(16'(usart.high_speed), 16'h0000);
		chk_cfg(usart.divider, 16'hABCD);
	endtask : t_baud

	task automatic t_spi_par;
		send('{8'hD1});
		chk_cfg(16'(spi.clock_idles_high_param), 16'h0001);
		chk_cfg(16'(spi.sample_late_param), 16'h0000);
		send('{8'hE1});
		chk_cfg(16'(spi.clock_idles_high_param), 16'h0000);
		chk_cfg(16'(spi.sample_late_param), 16'h0001);
	endtask : t_spi_par

	task automatic t_port_rw;
		send('{8'hC7, 8'h1F, 8'h0A, 8'h11, 8'h22});
		for (int p = 0; p < 5; p++) chk_res(exp_pin(p));
		chk_cfg(16'(latch[1]), 16'h0011);
		chk_cfg(16'(latch[3]), 16'h0022);
		chk_cfg(16'(latch[0]), 16'h0000);
	endtask : t_port_rw

	task automatic t_port_xor;
		send('{8'hC9, 8'h02, 8'h03, 8'hFF, 8'h0F});
		chk_res(exp_pin(1));
		chk_cfg(16'(latch[0]), 16'h00FF);
		chk_cfg(16'(latch[1]), 16'h001E);
	endtask : t_port_xor

	task automatic t_dir;
		chk_cfg(16'(dir[1]), 16'h00FF);
		send('{8'hE2, 8'h31, 8'h3C, 8'h0F, 8'hFF, 8'h55});
		chk_cfg(16'(dir[0]), 16'h00C3);
		chk_cfg(16'(dir[4]), 16'h005A);
	endtask : t_dir

	task automatic t_adc;
		logic [9:0] r;
		@(posedge core_clk_i);
		top <= 4'h2;
		send('{8'hC3});
		for (int c = 0; c < 3; c++) begin
			r = {2'(c), 4'(c), 4'h9};
			chk_res(r[7:0]);
			chk_res({cmp, 4'h0, r[9:8]});
		end
	endtask : t_adc

	// ==========================================================
	// Main sequence and verdict
	task automatic summarize;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	initial begin
		rst_i = 1'b1;
		slow = 1'b0;
		pins = {8'hC1, 8'h92, 8'hE3, 8'h74, 8'hF5};
		cmp = 2'h1;
		top = 4'h0;
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_spi_clock();
		t_baud();
		t_spi_par();
		slow = 1'b1;
		t_port_rw();
		t_port_xor();
		t_dir();
		t_adc();
		summarize();
	end
endmodule : ici_interp_tb_top
